// File: rtl/sdr_pkg.sv
// Package: register map, field layout and command codes of the SDRAM access/refresh block
package sdr_pkg;
   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFF_MEM_CTRL   = 8'h00;
   localparam logic [7:0] OFF_WAIT_CTRL2 = 8'h04;
   localparam logic [7:0] OFF_RT_CTRL    = 8'h08;
   localparam logic [7:0] OFF_RT_COUNT   = 8'h0c;
   localparam logic [7:0] OFF_RT_CONST   = 8'h10;
   localparam logic [7:0] OFF_STATUS     = 8'h14;
   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int F_TPC   = 0;   // 2 bits, precharge wait
   localparam int F_RCD   = 2;   // 2 bits, activate to command
   localparam int F_TRWL  = 4;   // 2 bits, write recovery
   localparam int F_REFRESH_RAS_CYCLES_FIELD  = 6;   // 3 bits, refresh RAS cycles
   localparam int F_REFRESH_MODE_BIT = 9;
   localparam int F_REFRESH_ENABLE_BIT  = 10;
   localparam int F_AMX   = 11;  // 2 bits, lo then hi
   localparam int F_A2LAT = 0;   // 2 bits in wait control 2
   localparam int F_A3LAT = 2;
   localparam logic [12:0] MEM_CTRL_RST   = 13'h0000;
   localparam logic [3:0]  WAIT_CTRL2_RST = 4'hf;
   localparam logic [2:0]  RT_CTRL_RST    = 3'h0;
   localparam logic [7:0]  RT_COUNT_RST   = 8'h00;
   localparam logic [7:0]  RT_CONST_RST   = 8'hff;
   // ****************************************
   // Commands {ras_n, cas_n, rdwr_n}
   // ****************************************
   localparam logic [2:0] CMD_NOP   = 3'h7;
   localparam logic [2:0] CMD_BANK_ACTIVATE_CMD  = 3'h3;
   localparam logic [2:0] CMD_READ  = 3'h5;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_REF   = 3'h1;
   localparam logic [3:0] BURST_BEATS = 4'h4;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ACT  = 6'h02,
      ST_RCDW = 6'h04,
      ST_XFER = 6'h08,
      ST_REF  = 6'h10,
      ST_REFW = 6'h20
   } sdr_state_t;
endpackage

// File: rtl/sdr_ctrl.sv
// SDRAM access sequencer, address multiplexer and auto-refresh timer with APB registers
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
module sdr_ctrl
   import sdr_pkg::*;
(
   // Clock and reset
   input  wire  logic         CLK,
   input  wire  logic         SRST,
   // APB slave
   input  wire  logic         PSEL,
   input  wire  logic         PENABLE,
   input  wire  logic         PWRITE,
   input  wire  logic [7:0]   PADDR,
   input  wire  logic [31:0]  PWDATA,
   output       logic [31:0]  PRDATA,
   output       logic         PREADY,
   output       logic         PSLVERR,
   // Access requests
   input  wire  logic         REQ,
   input  wire  logic         REQ_WRITE,
   input  wire  logic         REQ_BURST,
   input  wire  logic         REQ_AREA3,
   input  wire  logic [25:0]  REQ_ADDR,
   input  wire  logic [127:0] REQ_WDATA,
   output       logic         REQ_DONE,
   output       logic [31:0]  RD_DATA,
   output       logic         RD_VALID,
   // Memory bus
   input  wire  logic         EXTERNAL_COMMAND_CLOCK,
   output       logic [25:0]  SD_ADDR,
   output       logic         SD_RAS_N,
   output       logic         SD_CAS_N,
   output       logic         SD_RDWR_N,
   output       logic         SD_CS2_N,
   output       logic         SD_CS3_N,
   output       logic         SD_CKE,
   output       logic         BUS_CYCLE_STROBE_N,
   input  wire  logic [31:0]  SD_DQ_I,
   output       logic [31:0]  SD_DQ_O,
   output       logic         SD_DQ_OE
);
   // ****************************************
   // Pin multiplexer
   // ****************************************
   function automatic logic [25:0] mux_pins(input logic [25:0] a, input logic [1:0] amx,
                                            input logic row, input logic lh);
      logic [25:0] p;
      logic [4:0]  s;
      p = a;
      s = (amx == 2'b11) ? 5'h08 : 5'h08 + {3'h0, amx};
      if (row) begin
         for (int n = 1; n <= 15; n++) begin
            p[n] = a[5'(n) + s];
         end
      end else if (amx == 2'b11) begin
         p[10] = lh;
         p[11] = a[19];
      end else begin
         p[12] = lh;
         p[13] = a[5'h15 + {3'h0, amx}];
      end
      return p;
   endfunction

   // ****************************************
   // Registers and state
   // ****************************************
   logic [12:0]  mem_ctrl_reg;
   logic [3:0]   wait_ctrl2_reg;
   logic [2:0]   rt_ctrl_reg;
   logic [7:0]   rt_count_reg;
   logic [7:0]   rt_const_reg;
   logic [11:0]  presc_reg;
   logic         ref_pend_reg;
   sdr_state_t   state_reg;
   logic [3:0]   cnt_reg;
   logic [3:0]   busy_reg [2];
   logic [25:0]  addr_reg;
   logic         wr_reg;
   logic         burst_reg;
   logic         area3_reg;
   logic [127:0] wdata_reg;
   logic         ck_s1_reg;
   logic         ck_s2_reg;
   logic         ck_s3_reg;
   logic [31:0]  dq_s1_reg;
   logic [31:0]  dq_s2_reg;
   logic [31:0]  prdata_reg;
   logic         pready_reg;
   logic         pslverr_reg;
   logic         done_reg;
   logic [31:0]  rd_data_reg;
   logic         rd_valid_reg;
   logic [25:0]  pins_reg;
   logic [2:0]   cmd_reg;
   logic         cs2_n_reg;
   logic         cs3_n_reg;
   logic         cke_reg;
   logic         bs_n_reg;
   logic [31:0]  dq_o_reg;
   logic         dq_oe_reg;

   // ****************************************
   // Decode and selection
   // ****************************************
   wire        tick       = ck_s2_reg & ~ck_s3_reg;
   wire        apb_wr     = PSEL & PENABLE & PWRITE & pready_reg;
   wire        apb_setup  = PSEL & ~PENABLE;
   wire        sel_mem    = PADDR == OFF_MEM_CTRL;
   wire        sel_wait   = PADDR == OFF_WAIT_CTRL2;
   wire        sel_rtc    = PADDR == OFF_RT_CTRL;
   wire        sel_cnt    = PADDR == OFF_RT_COUNT;
   wire        sel_const  = PADDR == OFF_RT_CONST;
   wire        sel_stat   = PADDR == OFF_STATUS;
   wire        mapped     = sel_mem | sel_wait | sel_rtc | sel_cnt | sel_const | sel_stat;
   wire [1:0]  tpc        = mem_ctrl_reg[F_TPC +: 2];
   wire [1:0]  activate_delay_field        = mem_ctrl_reg[F_RCD +: 2];
   wire [1:0]  trwl       = mem_ctrl_reg[F_TRWL +: 2];
   wire [2:0]  refresh_ras_cycles_field       = mem_ctrl_reg[F_REFRESH_RAS_CYCLES_FIELD +: 3];
   wire        refresh_mode_bit      = mem_ctrl_reg[F_REFRESH_MODE_BIT];
   wire        refresh_enable_bit       = mem_ctrl_reg[F_REFRESH_ENABLE_BIT];
   wire [1:0]  amx        = mem_ctrl_reg[F_AMX +: 2];
   wire        auto_ref   = refresh_enable_bit & ~refresh_mode_bit;
   wire        self_ref   = refresh_enable_bit & refresh_mode_bit;
   // Divider taps: /4 up to /4096; select 0 stops the counter
   wire [11:0] tap_mask   = (rt_ctrl_reg == 3'h1) ? 12'h003 :
                            (rt_ctrl_reg == 3'h2) ? 12'h00f :
                            (rt_ctrl_reg == 3'h3) ? 12'h03f :
                            (rt_ctrl_reg == 3'h4) ? 12'h0ff :
                            (rt_ctrl_reg == 3'h5) ? 12'h3ff :
                            (rt_ctrl_reg == 3'h6) ? 12'h7ff : 12'hfff;
   wire        rt_tick    = (rt_ctrl_reg != 3'h0) && ((presc_reg & tap_mask) == tap_mask);
   wire        rt_match   = rt_count_reg == rt_const_reg;
   wire [1:0]  lat_raw    = area3_reg ? wait_ctrl2_reg[F_A3LAT +: 2]
                                      : wait_ctrl2_reg[F_A2LAT +: 2];
   wire [3:0]  lat        = (lat_raw == 2'h0) ? 4'h1 : {2'h0, lat_raw};
   wire [3:0]  beats      = burst_reg ? BURST_BEATS : 4'h1;
   wire [3:0]  last_cyc   = wr_reg ? beats - 4'h1 : lat + beats - 4'h1;
   wire [3:0]  next_cyc   = cnt_reg + 4'h1;
   wire        issue_more = next_cyc < beats;
   wire [1:0]  beat_col   = addr_reg[3:2] + next_cyc[1:0];
   wire [25:0] col_addr   = {addr_reg[25:4], beat_col, addr_reg[1:0]};
   wire        last_cmd   = next_cyc == beats - 4'h1;
   wire        cap_now    = ~wr_reg && (cnt_reg >= lat) && (cnt_reg < lat + beats);
   wire        cap_next   = ~wr_reg && (next_cyc >= lat) && (next_cyc < lat + beats);
   wire        req_free   = busy_reg[REQ_AREA3] == 4'h0;
   wire        start_ref  = ref_pend_reg & auto_ref & ~self_ref;
   wire        start_acc  = REQ & req_free & ~ref_pend_reg & ~self_ref;
   wire [3:0]  rec_wait   = wr_reg ? {2'h0, trwl} + {2'h0, tpc} + 4'h2 : {2'h0, tpc} + 4'h1;
   wire [31:0] status     = {26'h0, state_reg == ST_IDLE, ref_pend_reg, busy_reg[1] != 4'h0,
                             busy_reg[0] != 4'h0, self_ref, auto_ref};
   wire [31:0] rd_mux     = sel_mem   ? {19'h0, mem_ctrl_reg} :
                            sel_wait  ? {28'h0, wait_ctrl2_reg} :
                            sel_rtc   ? {29'h0, rt_ctrl_reg} :
                            sel_cnt   ? {24'h0, rt_count_reg} :
                            sel_const ? {24'h0, rt_const_reg} :
                            sel_stat  ? status : 32'h0;

   // ****************************************
   // Synchronisers
   // ****************************************
   // The link clock is only sampled; edges are found one tap behind the second stage
   always_ff @(posedge CLK) begin
      ck_s1_reg <= EXTERNAL_COMMAND_CLOCK;
      ck_s2_reg <= ck_s1_reg;
      ck_s3_reg <= ck_s2_reg;
      dq_s1_reg <= SD_DQ_I;
      dq_s2_reg <= dq_s1_reg;
   end

   // ****************************************
   // APB slave, zero wait states
   // ****************************************
   always_ff @(posedge CLK) begin
      if (SRST) begin
         pready_reg     <= 1'b0;
         pslverr_reg    <= 1'b0;
         prdata_reg     <= 32'h0;
         mem_ctrl_reg   <= MEM_CTRL_RST;
         wait_ctrl2_reg <= WAIT_CTRL2_RST;
         rt_ctrl_reg    <= RT_CTRL_RST;
         rt_const_reg   <= RT_CONST_RST;
      end else begin
         pready_reg  <= apb_setup;
         pslverr_reg <= apb_setup & ~mapped;
         if (apb_setup & ~PWRITE) begin
            prdata_reg <= rd_mux;
         end
         if (apb_wr & sel_mem) begin
            mem_ctrl_reg <= PWDATA[12:0];
         end
         if (apb_wr & sel_wait) begin
            wait_ctrl2_reg <= PWDATA[3:0];
         end
         if (apb_wr & sel_rtc) begin
            rt_ctrl_reg <= PWDATA[2:0];
         end
         if (apb_wr & sel_const) begin
            rt_const_reg <= PWDATA[7:0];
         end
      end
   end

   // ****************************************
   // Refresh timer
   // ****************************************
   // Runs on its own divider so requester sleep or stall never stops it
   always_ff @(posedge CLK) begin
      if (SRST) begin
         presc_reg    <= 12'h0;
         rt_count_reg <= RT_COUNT_RST;
         ref_pend_reg <= 1'b0;
      end else begin
         presc_reg <= presc_reg + 12'h1;
         if (apb_wr & sel_cnt) begin
            rt_count_reg <= PWDATA[7:0];
         end else if (rt_match & auto_ref) begin
            rt_count_reg <= 8'h0;
         end else if (rt_tick) begin
            rt_count_reg <= rt_count_reg + 8'h1;
         end
         // A new match merges into the pending one; set wins over the clear
         if (rt_match & auto_ref) begin
            ref_pend_reg <= 1'b1;
         end else if (tick && state_reg == ST_IDLE && start_ref) begin
            ref_pend_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // Access and refresh sequencer
   // ****************************************
   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 4'h0;
         busy_reg  <= '{4'h0, 4'h0};
         addr_reg  <= 26'h0;
         wr_reg    <= 1'b0;
         burst_reg <= 1'b0;
         area3_reg <= 1'b0;
         wdata_reg <= 128'h0;
         done_reg  <= 1'b0;
         rd_valid_reg <= 1'b0;
         rd_data_reg  <= 32'h0;
         pins_reg  <= 26'h0;
         cmd_reg   <= CMD_NOP;
         cs2_n_reg <= 1'b1;
         cs3_n_reg <= 1'b1;
         bs_n_reg  <= 1'b1;
         dq_o_reg  <= 32'h0;
         dq_oe_reg <= 1'b0;
         cke_reg   <= 1'b1;
      end else begin
         cke_reg      <= ~self_ref;
         done_reg     <= 1'b0;
         rd_valid_reg <= 1'b0;
         if (tick) begin
            cmd_reg   <= CMD_NOP;
            bs_n_reg  <= 1'b1;
            dq_oe_reg <= 1'b0;
            for (int b = 0; b < 2; b++) begin
               if (busy_reg[b] != 4'h0) begin
                  busy_reg[b] <= busy_reg[b] - 4'h1;
               end
            end
            case (state_reg)
               ST_IDLE: begin
                  cs2_n_reg <= 1'b1;
                  cs3_n_reg <= 1'b1;
                  if (start_ref) begin
                     cmd_reg   <= CMD_REF;
                     cs2_n_reg <= 1'b0;
                     cs3_n_reg <= 1'b0;
                     state_reg <= ST_REF;
                  end else if (start_acc) begin
                     addr_reg  <= REQ_ADDR;
                     wr_reg    <= REQ_WRITE;
                     burst_reg <= REQ_BURST;
                     area3_reg <= REQ_AREA3;
                     wdata_reg <= REQ_WDATA;
                     cmd_reg   <= CMD_BANK_ACTIVATE_CMD;
                     pins_reg  <= mux_pins(REQ_ADDR, amx, 1'b1, 1'b0);
                     cs2_n_reg <= REQ_AREA3;
                     cs3_n_reg <= ~REQ_AREA3;
                     cnt_reg   <= {2'h0, activate_delay_field};
                     state_reg <= ST_RCDW;
                  end
               end
               ST_RCDW: begin
                  if (cnt_reg == 4'h0) begin
                     // First command; last of a single access auto-precharges
                     cmd_reg   <= wr_reg ? CMD_WRITE : CMD_READ;
                     pins_reg  <= mux_pins({addr_reg[25:4], addr_reg[3:2], addr_reg[1:0]},
                                           amx, 1'b0, ~burst_reg);
                     dq_o_reg  <= wdata_reg[32 * addr_reg[3:2] +: 32];
                     dq_oe_reg <= wr_reg;
                     bs_n_reg  <= ~(wr_reg | lat == 4'h0);
                     cnt_reg   <= 4'h0;
                     state_reg <= ST_XFER;
                  end else begin
                     cnt_reg <= cnt_reg - 4'h1;
                  end
               end
               ST_XFER: begin
                  cnt_reg <= next_cyc;
                  if (cap_now) begin
                     rd_data_reg  <= dq_s2_reg;
                     rd_valid_reg <= 1'b1;
                  end
                  if (issue_more) begin
                     cmd_reg   <= wr_reg ? CMD_WRITE : CMD_READ;
                     pins_reg  <= mux_pins(col_addr, amx, 1'b0, last_cmd);
                     dq_o_reg  <= wdata_reg[32 * beat_col +: 32];
                     dq_oe_reg <= wr_reg;
                  end
                  bs_n_reg <= ~((wr_reg & issue_more) | cap_next);
                  if (cnt_reg == last_cyc) begin
                     busy_reg[area3_reg] <= rec_wait;
                     done_reg  <= 1'b1;
                     bs_n_reg  <= 1'b1;
                     state_reg <= ST_IDLE;
                  end
               end
               ST_REF: begin
                  cs2_n_reg <= 1'b1;
                  cs3_n_reg <= 1'b1;
                  cnt_reg   <= {1'h0, refresh_ras_cycles_field} + {2'h0, tpc} + 4'h1;
                  state_reg <= ST_REFW;
               end
               ST_REFW: begin
                  if (cnt_reg == 4'h0) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     cnt_reg <= cnt_reg - 4'h1;
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign PRDATA             = prdata_reg;
   assign PREADY             = pready_reg;
   assign PSLVERR            = pslverr_reg;
   assign REQ_DONE           = done_reg;
   assign RD_DATA            = rd_data_reg;
   assign RD_VALID           = rd_valid_reg;
   assign SD_ADDR            = pins_reg;
   assign {SD_RAS_N, SD_CAS_N, SD_RDWR_N} = cmd_reg;
   assign SD_CS2_N           = cs2_n_reg;
   assign SD_CS3_N           = cs3_n_reg;
   assign SD_CKE             = cke_reg;
   assign BUS_CYCLE_STROBE_N = bs_n_reg;
   assign SD_DQ_O            = dq_o_reg;
   assign SD_DQ_OE           = dq_oe_reg;

   // ****************************************
   // Assertions
   // ****************************************
   a_cke_self_ref: assert property (@(posedge CLK) disable iff (SRST)
      ##1 (SD_CKE == ~$past(self_ref)))
      else $error("clock enable does not follow self-refresh");
   a_counter_clear: assert property (@(posedge CLK) disable iff (SRST)
      (rt_match && auto_ref && !(apb_wr && sel_cnt)) |=> (rt_count_reg == 8'h0) && ref_pend_reg)
      else $error("refresh match did not clear counter or raise request");
   a_rcd_nop: assert property (@(posedge CLK) disable iff (SRST)
      (tick && state_reg == ST_RCDW && cnt_reg != 4'h0) |=> (cmd_reg == CMD_NOP))
      else $error("no NOP after activate with long delay");
   a_act_bank_free: assert property (@(posedge CLK) disable iff (SRST)
      $rose(cmd_reg == CMD_BANK_ACTIVATE_CMD)
         |-> ((SD_CS2_N ? $past(busy_reg[1]) : $past(busy_reg[0])) == 4'h0))
      else $error("activate to a bank still precharging");
   a_bs_on_data: assert property (@(posedge CLK) disable iff (SRST)
      RD_VALID |-> $past(bs_n_reg == 1'b0))
      else $error("read data captured outside strobed data cycle");
   a_data_with_cmd: assert property (@(posedge CLK) disable iff (SRST)
      (SD_DQ_OE) |-> (cmd_reg == CMD_WRITE))
      else $error("write data driven without write command");
   a_fixed_pins: assert property (@(posedge CLK) disable iff (SRST)
      (cmd_reg != CMD_NOP && cmd_reg != CMD_REF)
         |-> (SD_ADDR[25:16] == addr_reg[25:16]) && (SD_ADDR[0] == addr_reg[0]))
      else $error("unmultiplexed address pin changed");
   a_ref_blocks: assert property (@(posedge CLK) disable iff (SRST)
      (state_reg == ST_REFW) |-> (cmd_reg == CMD_NOP))
      else $error("command issued during refresh recovery");
   a_apb_unmapped: assert property (@(posedge CLK) disable iff (SRST)
      (PSEL && !PENABLE && !mapped) |=> PREADY && PSLVERR)
      else $error("unmapped access not flagged");
endmodule // sdr_ctrl

// File: tb/sdr_mem_model.sv
// Behavioural SDRAM chip model answering reads after the programmed CAS latency
`timescale 1ns/1ps
module sdr_mem_model
   import sdr_pkg::*;
(
   // Command side
   input  wire  logic        ck,
   input  wire  logic [1:0]  lat,
   input  wire  logic [25:0] addr,
   input  wire  logic [2:0]  cmd,
   input  wire  logic        sel_n,
   // Data side
   output       logic [31:0] dq
);
   logic [3:0]      vld_reg = 4'h0;
   logic [3:0][7:0] col_reg;
   initial dq = 32'h0000_0000;
   // Commands are taken on the rising edge, as a real chip does
   always @(posedge ck) begin
      vld_reg <= {vld_reg[2:0], !sel_n && cmd == CMD_READ};
      col_reg <= {col_reg[2:0], addr[9:2]};
   end
   // Data centred on the latency edge; an idle bus toggles so stale data never matches
   always @(negedge ck) begin
      if (vld_reg[lat - 2'h1])
         dq <= 32'h5a5a_0000 | {24'h0, col_reg[lat - 2'h1]};
      else
         dq <= ~dq;
   end
endmodule // sdr_mem_model

// File: tb/sdr_ctrl_bench.sv
// Self-checking bench for the SDRAM access and refresh controller
`timescale 1ns/1ps
module sdr_ctrl_bench
   import sdr_pkg::*;
;
   typedef struct packed {
      logic w, b, a3;
      logic [1:0] amx, lat, activate_delay_field;
      logic [25:0] a;
   } sdr_case_t;
   logic CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, REQ = 0, EXT = 0, err;
   logic REQ_WRITE = 0, REQ_BURST = 0, REQ_AREA3 = 0, PREADY, PSLVERR, REQ_DONE, RD_VALID;
   logic SD_RAS_N, SD_CAS_N, SD_RDWR_N, SD_CS2_N, SD_CS3_N, SD_CKE, BUS_CYCLE_STROBE_N;
   logic SD_DQ_OE;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, RD_DATA, SD_DQ_I, SD_DQ_O, rd, ex;
   logic [25:0] REQ_ADDR = 26'h0, SD_ADDR, row, tmp;
   logic [127:0] REQ_WDATA = 128'h4444_4444_3333_3333_2222_2222_1111_1111;
   logic [1:0] lat = 2'h1;
   logic [25:0] colq[$];
   logic [31:0] dq_q[$], rdq[$];
   int mismatches = 0, comparisons = 0, edge_n = 0, act_e = 0, first_e = 0, refs = 0;
   wire [2:0] cmd = {SD_RAS_N, SD_CAS_N, SD_RDWR_N};
   sdr_case_t c;
   sdr_case_t rows [8] = '{'{0, 1, 0, 0, 1, 0, 26'h2a555a4}, '{0, 1, 1, 1, 2, 1, 26'h3c1234c},
      '{0, 0, 0, 2, 3, 3, 26'h1f00008}, '{0, 1, 1, 3, 3, 2, 26'h2bcdef0},
      '{1, 1, 0, 0, 1, 1, 26'h1234568}, '{1, 0, 1, 3, 1, 0, 26'h3fffffc},
      '{0, 0, 1, 1, 1, 0, 26'h000000c}, '{1, 1, 1, 2, 2, 3, 26'h155554c}};
   sdr_ctrl sdr_ctrl_i (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .REQ(REQ), .REQ_WRITE(REQ_WRITE), .REQ_BURST(REQ_BURST),
      .REQ_AREA3(REQ_AREA3), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_DONE(REQ_DONE),
      .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .EXTERNAL_COMMAND_CLOCK(EXT), .SD_ADDR(SD_ADDR),
      .SD_RAS_N(SD_RAS_N), .SD_CAS_N(SD_CAS_N), .SD_RDWR_N(SD_RDWR_N), .SD_CS2_N(SD_CS2_N),
      .SD_CS3_N(SD_CS3_N), .SD_CKE(SD_CKE), .BUS_CYCLE_STROBE_N(BUS_CYCLE_STROBE_N),
      .SD_DQ_I(SD_DQ_I), .SD_DQ_O(SD_DQ_O), .SD_DQ_OE(SD_DQ_OE));
   sdr_mem_model sdr_mem_model_i (.ck(EXT), .lat(lat), .addr(SD_ADDR), .cmd(cmd),
      .sel_n(SD_CS2_N & SD_CS3_N), .dq(SD_DQ_I));
   initial forever #12.5 CLK = ~CLK;
   // Offset so link edges never line up with the system clock
   initial begin
      #37;
      forever #100 EXT = ~EXT;
   end
   // Record what the chips see at each command clock edge
   always @(posedge EXT) begin
      edge_n++;
      if (!(SD_CS2_N && SD_CS3_N)) begin
         if (cmd == CMD_BANK_ACTIVATE_CMD) begin
            row = SD_ADDR;
            act_e = edge_n;
         end
         if (cmd == CMD_READ || cmd == CMD_WRITE) begin
            if (colq.size() == 0)
               first_e = edge_n;
            colq.push_back(SD_ADDR);
            dq_q.push_back(SD_DQ_OE ? SD_DQ_O : 32'hx);
         end
         if (cmd == CMD_REF && !SD_CS2_N && !SD_CS3_N)
            refs++;
      end
   end
   always @(posedge CLK)
      if (RD_VALID)
         rdq.push_back(RD_DATA);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic give_up;
      mismatches++;
      conclude();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge CLK);
      PSEL <= 1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge CLK);
         if (PREADY === 1'b1)
            break;
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
      if (n == 50)
         give_up();
   endtask
   task automatic access(input logic w, b, a3, input logic [25:0] a);
      int n;
      @(posedge CLK);
      REQ <= 1;
      REQ_WRITE <= w;
      REQ_BURST <= b;
      REQ_AREA3 <= a3;
      REQ_ADDR <= a;
      for (n = 0; n < 3000 && REQ_DONE !== 1'b1; n++)
         @(posedge CLK);
      REQ <= 0;
      if (n == 3000)
         give_up();
   endtask
   initial begin
      repeat (12) @(posedge CLK);
      SRST <= 0;
      apb(0, OFF_WAIT_CTRL2, 0);
      check(rd, 32'(WAIT_CTRL2_RST));
      apb(0, OFF_RT_CONST, 0);
      check(rd, 32'(RT_CONST_RST));
      check(SD_CKE, 1);
      apb(0, 8'h3c, 32'hffff_ffff);
      check(err, 1);
      foreach (rows[i]) begin
         c = rows[i];
         lat <= c.lat;
         apb(1, OFF_MEM_CTRL, {19'h0, c.amx, 7'h0, c.activate_delay_field, 2'h0});
         apb(1, OFF_WAIT_CTRL2, {28'h0, c.lat, c.lat});
         colq.delete();
         dq_q.delete();
         rdq.delete();
         access(c.w, c.b, c.a3, c.a);
         repeat (4) @(posedge CLK);
         tmp = c.a >> (c.amx == 3 ? 8 : 8 + c.amx);
         ex = c.a;
         ex[15:1] = tmp[15:1];
         check(row, ex);
         check(first_e - act_e, c.activate_delay_field + 1);
         check(colq.size(), c.b ? 4 : 1);
         for (int k = 0; k < colq.size(); k++) begin
            ex = c.a;
            ex[3:2] = c.a[3:2] + k[1:0];
            ex[c.amx == 3 ? 10 : 12] = k == colq.size() - 1;
            ex[c.amx == 3 ? 11 : 13] = c.a[c.amx == 3 ? 19 : 21 + c.amx];
            check(colq[k], ex);
            if (c.w)
               check(dq_q[k], REQ_WDATA[32 * ex[3:2] +: 32]);
            else
               check(rdq[k], 32'h5a5a_0000 | ex[9:2]);
         end
      end
      apb(1, OFF_RT_CONST, 32'h6);
      apb(1, OFF_RT_COUNT, 32'h0);
      apb(1, OFF_MEM_CTRL, 32'h400);
      apb(1, OFF_RT_CTRL, 32'h1);
      refs = 0;
      rdq.delete();
      access(0, 0, 0, 26'h40);
      repeat (4) @(posedge CLK);
      check(rdq[0], 32'h5a5a_0010);
      for (int n = 0; n < 3000 && refs < 3; n++)
         @(posedge CLK);
      check(refs > 2, 1);
      apb(1, OFF_RT_CTRL, 32'h0);
      apb(1, OFF_MEM_CTRL, 32'h600);
      repeat (80) @(posedge CLK);
      check(SD_CKE, 0);
      apb(1, OFF_MEM_CTRL, 32'h0);
      repeat (80) @(posedge CLK);
      check(SD_CKE, 1);
      apb(1, OFF_MEM_CTRL, 32'h600);
      SRST <= 1;
      repeat (4) @(posedge CLK);
      SRST <= 0;
      apb(0, OFF_MEM_CTRL, 0);
      check(rd, 32'(MEM_CTRL_RST));
      check(SD_CKE, 1);
      conclude();
   end
endmodule // sdr_ctrl_bench
